/* File: rtl/lsf_pkg.sv */
// Shared constants and types for the load switch fault sequencer
//------------------------------------------------------------------
//------------------------------------------------------------------
package lsf_pkg;
    //------------------------------------------------------------------
    // Timing
    //------------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int CNT_W = 26;
    localparam int T_DEB_US = 1000;
    localparam int T_ON_INNER_US = 500;
    localparam int T_ON_OUTER_US = 500;
    localparam int T_STI_US = 24000;
    localparam int T_STO_US = 50000;
    localparam int T_BLANK_US = 24000;
    localparam int T_RETRY_US = 720000;
    localparam int T_OCP_OFF_US = 500;
    localparam int SYNC_W = 18;

    // Microseconds to whole clock cycles
    function automatic int lsf_cyc(input int us);
        return us * CLK_MHZ;
    endfunction

    //------------------------------------------------------------------
    // Limit modes
    //------------------------------------------------------------------
    typedef enum logic [1:0] {LSF_CONT, LSF_AUTO, LSF_LATCH} lsf_mode_t;
endpackage

/* File: rtl/lsf_sync.sv */
// Two flip-flop synchroniser for a vector of comparator and pin levels
`timescale 1ns/1ps
module lsf_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* File: rtl/lsf_timer.sv */
// Loadable down counter that reports when it has run out
`timescale 1ns/1ps
module lsf_timer #(
    parameter int W = 26
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_value,
    output logic expired
);
    logic [W-1:0] count;

    assign expired = (count == '0);

    // Load wins over counting so a restart never sees a stale count
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (ce) begin
            if (load) begin
                count <= load_value;
            end else if (!expired) begin
                count <= count - W'(1);
            end
        end
    end
endmodule

/* File: rtl/lsf_seq.sv */
// Turn-on, fault and current-limit mode sequencer for the protected switch
`timescale 1ns/1ps
module lsf_seq
    import lsf_pkg::*;
#(
    parameter int DEB_CYC = lsf_cyc(T_DEB_US),
    parameter int ON_INNER_CYC = lsf_cyc(T_ON_INNER_US),
    parameter int ON_OUTER_CYC = lsf_cyc(T_ON_OUTER_US),
    parameter int STI_CYC = lsf_cyc(T_STI_US),
    parameter int STO_CYC = lsf_cyc(T_STO_US),
    parameter int BLANK_CYC = lsf_cyc(T_BLANK_US),
    parameter int RETRY_CYC = lsf_cyc(T_RETRY_US),
    parameter int OCP_OFF_CYC = lsf_cyc(T_OCP_OFF_US)
) (
    // Clock, reset, clock enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    // Enable pins from the supervisor
    input wire logic high_voltage_enable_n,
    input wire logic low_voltage_enable,
    // Undervoltage and overvoltage comparators
    input wire logic uv_select_above,
    input wire logic uv_internal_below,
    input wire logic uv_external_below,
    input wire logic ov_select_above,
    input wire logic ov_internal_above,
    input wire logic ov_external_above,
    // Output, thermal and current comparators
    input wire logic out_above_uv_level,
    input wire logic drop_alarm,
    input wire logic thermal_shutdown,
    input wire logic thermal_foldback,
    input wire logic overcurrent,
    input wire logic severe_overcurrent,
    // Limit-setting pin and mode select comparators
    input wire logic limit_set_low,
    input wire logic limit_set_open,
    input wire logic limit_mode_grounded,
    input wire logic limit_mode_open,
    // Switch drive
    output logic inner_switch_on,
    output logic outer_switch_on,
    // Current regulator control
    output logic current_limit_hold,
    output logic thermal_regulate,
    output logic current_block,
    output lsf_mode_t limit_mode,
    // Trip level selection in use
    output logic uv_external_sel,
    output logic ov_external_sel,
    // Open-drain fault pin
    output logic fault_out_n,
    output logic fault_pin_out,
    output logic fault_pin_oe_n
);
    //------------------------------------------------------------------
    // Synchronised inputs
    //------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF, ST_DEBOUNCE, ST_INNER_WAIT, ST_OUTER_WAIT,
        ST_STARTUP, ST_RUN, ST_RETRY, ST_OCP_OFF
    } lsf_state_t;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic high_voltage_enable_n_s, en_s, uvsel_s, uvint_s, uvext_s, ovsel_s, ovint_s, ovext_s;
    logic outok_s, drop_s, tshut_s, tfold_s, oc_s, severe_s;
    logic setlow_s, setopen_s, modegnd_s, modeopen_s;

    assign pins_raw = {high_voltage_enable_n, low_voltage_enable,
                       uv_select_above, uv_internal_below, uv_external_below,
                       ov_select_above, ov_internal_above, ov_external_above,
                       out_above_uv_level, drop_alarm, thermal_shutdown,
                       thermal_foldback, overcurrent, severe_overcurrent,
                       limit_set_low, limit_set_open,
                       limit_mode_grounded, limit_mode_open};

    // Every comparator flag crosses two flops before use
    lsf_sync #(.W(SYNC_W)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ce(ce),
        .d(pins_raw),
        .q(pins_s)
    );

    assign {high_voltage_enable_n_s, en_s, uvsel_s, uvint_s, uvext_s, ovsel_s, ovint_s, ovext_s,
            outok_s, drop_s, tshut_s, tfold_s, oc_s, severe_s,
            setlow_s, setopen_s, modegnd_s, modeopen_s} = pins_s;

    //------------------------------------------------------------------
    // State and flags
    //------------------------------------------------------------------
    lsf_state_t state;
    lsf_state_t next_state;
    logic latched, limit_set_pin_bad, check_pending, restart_by_fault, fault_hold;
    logic high_voltage_enable_n_prev, en_prev;
    logic [1:0] warm;
    logic tmr_exp, blank_exp, tmr_load, blank_load;
    logic [CNT_W-1:0] tmr_val;
    logic [CNT_W-1:0] blank_val;

    //------------------------------------------------------------------
    // Decoding
    //------------------------------------------------------------------
    // Only enable_n high with enable low commands off
    wire en_on = !(high_voltage_enable_n_s && !en_s);
    // Trip level follows the select comparator
    wire uv_fault = uvsel_s ? uvext_s : uvint_s;
    wire ov_fault = ovsel_s ? ovext_s : ovint_s;
    wire vfault = uv_fault || ov_fault;
    wire en_toggle = (high_voltage_enable_n_s != high_voltage_enable_n_prev) || (en_s != en_prev);
    wire switch_live = (state == ST_STARTUP) || (state == ST_RUN);
    // Grounded autoretry, open continuous, resistor latch-off
    wire lsf_mode_t mode_pick = modegnd_s ? LSF_AUTO :
                                modeopen_s ? LSF_CONT : LSF_LATCH;
    wire blank_trip = (state == ST_RUN) && oc_s && blank_exp &&
                      (limit_mode != LSF_CONT);
    wire sto_fail = (state == ST_STARTUP) && drop_s && tmr_exp;
    wire latch_set = sto_fail || (blank_trip && limit_mode == LSF_LATCH);
    // Enable toggle or a supply dip clears the latch
    wire latch_clr = en_toggle || uv_fault;
    wire sync_ok = warm[1]; // Reset zeros in the synchroniser would read as enable on
    wire check_now = sync_ok && state == ST_OFF && en_on && !vfault && !tshut_s && check_pending;
    wire start_ok = sync_ok && !latched && !limit_set_pin_bad && !(check_pending && setlow_s);
    // Fault recovery with a charged output needs no debounce
    wire skip_deb = restart_by_fault && outok_s;
    wire fault_now = fault_hold || vfault || drop_s || tshut_s || limit_set_pin_bad;

    //------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------
    // Loss of enable, a voltage fault or overheating overrides every state
    always_comb begin
        next_state = state;
        if (!en_on || vfault || tshut_s) begin
            next_state = ST_OFF;
        end else if (severe_s && (state == ST_OUTER_WAIT || switch_live)) begin
            next_state = ST_OCP_OFF;
        end else begin
            unique case (state)
                ST_OFF: begin
                    if (start_ok) begin
                        next_state = skip_deb ? ST_INNER_WAIT : ST_DEBOUNCE;
                    end
                end
                ST_DEBOUNCE: begin
                    if (tmr_exp) begin
                        next_state = ST_INNER_WAIT;
                    end
                end
                ST_INNER_WAIT: begin
                    if (tmr_exp) begin
                        next_state = ST_OUTER_WAIT;
                    end
                end
                ST_OUTER_WAIT: begin
                    if (tmr_exp) begin
                        next_state = ST_STARTUP;
                    end
                end
                ST_STARTUP: begin
                    if (!drop_s) begin
                        next_state = ST_RUN;
                    end else if (tmr_exp) begin
                        next_state = ST_OFF;
                    end
                end
                ST_RUN: begin
                    if (blank_trip) begin
                        next_state = (limit_mode == LSF_AUTO) ? ST_RETRY : ST_OFF;
                    end
                end
                ST_RETRY: begin
                    if (tmr_exp) begin
                        next_state = ST_INNER_WAIT;
                    end
                end
                ST_OCP_OFF: begin
                    if (tmr_exp) begin
                        next_state = outok_s ? ST_INNER_WAIT : ST_DEBOUNCE;
                    end
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // Timers
    //------------------------------------------------------------------
    // Main timer reloads on each state change with the new state's delay
    always_comb begin
        tmr_val = CNT_W'(1);
        unique case (next_state)
            ST_DEBOUNCE: tmr_val = CNT_W'(DEB_CYC);
            ST_INNER_WAIT: tmr_val = CNT_W'(ON_INNER_CYC);
            ST_OUTER_WAIT: tmr_val = CNT_W'(ON_OUTER_CYC);
            ST_STARTUP: tmr_val = CNT_W'(STO_CYC);
            ST_RETRY: tmr_val = CNT_W'(RETRY_CYC);
            ST_OCP_OFF: tmr_val = CNT_W'(OCP_OFF_CYC);
            ST_OFF, ST_RUN: tmr_val = CNT_W'(1);
        endcase
    end

    assign tmr_load = (next_state != state);

    // Second timer times the startup limit window, then blanking;
    // it is held loaded while overcurrent is absent so short events reset it
    assign blank_load = (state != ST_STARTUP || next_state != ST_STARTUP) &&
                        !(state == ST_RUN && oc_s);
    assign blank_val = (next_state == ST_RUN) ? CNT_W'(BLANK_CYC) : CNT_W'(STI_CYC);

    lsf_timer #(.W(CNT_W)) u_tmr (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ce(ce),
        .load(tmr_load),
        .load_value(tmr_val),
        .expired(tmr_exp)
    );

    lsf_timer #(.W(CNT_W)) u_blank (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ce(ce),
        .load(blank_load),
        .load_value(blank_val),
        .expired(blank_exp)
    );

    //------------------------------------------------------------------
    // Sequencer registers
    //------------------------------------------------------------------
    // Reset parks everything off with continuous limiting and check pending
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_OFF;
            limit_mode <= LSF_CONT;
            check_pending <= 1'b1;
            latched <= 1'b0;
            limit_set_pin_bad <= 1'b0;
            restart_by_fault <= 1'b0;
            fault_hold <= 1'b0;
            high_voltage_enable_n_prev <= 1'b0;
            en_prev <= 1'b0;
            warm <= 2'b00;
        end else if (ce) begin
            state <= next_state;
            warm <= {warm[0], 1'b1};
            high_voltage_enable_n_prev <= high_voltage_enable_n_s;
            en_prev <= en_s;
            // Mode is read only once startup has succeeded
            if (state == ST_STARTUP && next_state == ST_RUN) begin
                limit_mode <= mode_pick;
            end
            // Resistor checked on the first exit from shutdown only
            if (check_now) begin
                check_pending <= 1'b0;
                limit_set_pin_bad <= setlow_s;
            end
            // Set wins over clear on the same edge
            latched <= latch_set || (latched && !latch_clr);
            // Voltage faults mark the next start as a recovery start
            restart_by_fault <= vfault || (restart_by_fault && en_on);
            fault_hold <= vfault || (fault_hold && next_state != ST_STARTUP);
        end
    end

    // Switch, hold and thermal outputs follow the next state so they line up with the state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            inner_switch_on <= 1'b0;
            outer_switch_on <= 1'b0;
            current_limit_hold <= 1'b1;
            thermal_regulate <= 1'b0;
            current_block <= 1'b0;
            uv_external_sel <= 1'b0;
            ov_external_sel <= 1'b0;
            fault_out_n <= 1'b1;
        end else if (ce) begin
            inner_switch_on <= (next_state == ST_OUTER_WAIT) || (next_state == ST_STARTUP) ||
                               (next_state == ST_RUN);
            outer_switch_on <= (next_state == ST_STARTUP) || (next_state == ST_RUN);
            current_limit_hold <= (next_state == ST_STARTUP) &&
                                  (state != ST_STARTUP || !blank_exp);
            thermal_regulate <= (next_state == ST_STARTUP) && tfold_s;
            current_block <= setopen_s;
            uv_external_sel <= uvsel_s;
            ov_external_sel <= ovsel_s;
            fault_out_n <= !fault_now;
        end
    end

    // Open drain: pin driven low only while the fault is shown
    assign fault_pin_out = 1'b0;
    assign fault_pin_oe_n = fault_out_n;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    wire off_cmd = high_voltage_enable_n_s && !en_s;

    sequence s_outer_rise;
        !outer_switch_on ##1 outer_switch_on;
    endsequence

    property p_enable_off;
        @(posedge clk_sys) disable iff (!reset_n)
        (ce && off_cmd) |=> (!inner_switch_on && !outer_switch_on);
    endproperty
    a_enable_off: assert property (p_enable_off)
        else $error("switch stays on while enables command off");

    property p_uv_off;
        @(posedge clk_sys) disable iff (!reset_n)
        (ce && uv_fault) |=> (!inner_switch_on && !fault_out_n);
    endproperty
    a_uv_off: assert property (p_uv_off)
        else $error("undervoltage did not force switch off with fault");

    property p_ov_off;
        @(posedge clk_sys) disable iff (!reset_n)
        (ce && ov_fault) |=> (!inner_switch_on && !outer_switch_on && !fault_out_n);
    endproperty
    a_ov_off: assert property (p_ov_off)
        else $error("overvoltage did not force switch off with fault");

    property p_staged_on;
        @(posedge clk_sys) disable iff (!reset_n)
        s_outer_rise |-> $past(inner_switch_on) && $past(inner_switch_on, 2) && current_limit_hold;
    endproperty
    a_staged_on: assert property (p_staged_on)
        else $error("outer switch came on without the inner switch first");

    property p_severe;
        @(posedge clk_sys) disable iff (!reset_n)
        (ce && severe_s && switch_live && en_on && !vfault && !tshut_s)
            |=> (!inner_switch_on && !outer_switch_on && state == ST_OCP_OFF);
    endproperty
    a_severe: assert property (p_severe)
        else $error("severe overcurrent did not turn both switches off");

    property p_sto_latch;
        @(posedge clk_sys) disable iff (!reset_n)
        (ce && sto_fail) |=> (latched && !outer_switch_on);
    endproperty
    a_sto_latch: assert property (p_sto_latch)
        else $error("startup timeout did not latch the switch off");

    property p_mode_sample;
        @(posedge clk_sys) disable iff (!reset_n)
        $changed(limit_mode) |-> ($past(state) == ST_STARTUP && state == ST_RUN);
    endproperty
    a_mode_sample: assert property (p_mode_sample)
        else $error("limit mode changed outside the startup exit");

    property p_open_block;
        @(posedge clk_sys) disable iff (!reset_n)
        (ce && setopen_s) |=> current_block;
    endproperty
    a_open_block: assert property (p_open_block)
        else $error("open limit pin did not block current");

    property p_debounce;
        @(posedge clk_sys) disable iff (!reset_n)
        (ce && state == ST_DEBOUNCE && !tmr_exp) |=> !inner_switch_on;
    endproperty
    a_debounce: assert property (p_debounce)
        else $error("inner switch came on before debounce ended");

    property p_toggle_clear;
        @(posedge clk_sys) disable iff (!reset_n)
        (ce && en_toggle && !latch_set) |=> !latched;
    endproperty
    a_toggle_clear: assert property (p_toggle_clear)
        else $error("enable toggle did not clear the latched fault");
endmodule

/* File: tb/lsf_super.sv */
// Supervisory side model: enable pins out, open-drain fault pin in
`timescale 1ns/1ps
module lsf_super (
    // Clock and command from the bench
    input wire logic clk_sys,
    input wire logic [1:0] cmd,
    // Enable pins
    output logic high_voltage_enable_n,
    output logic low_voltage_enable,
    // Fault pin
    input wire logic fault_pin_out,
    input wire logic fault_pin_oe_n,
    output logic fault_seen
);
    // Start in the off pair so nothing is commanded before the bench asks
    initial begin
        high_voltage_enable_n = 1'b1;
        low_voltage_enable = 1'b0;
    end
    // Pins change only just after an edge; toggling clears latched faults
    always @(posedge clk_sys) begin
        high_voltage_enable_n <= cmd[1];
        low_voltage_enable <= cmd[0];
    end
    // Pull-up: a released pin reads high, never the last driven value
    assign fault_seen = fault_pin_oe_n ? 1'b1 : fault_pin_out;
endmodule

/* File: tb/tb_lsf_seq.sv */
// Self-checking bench for the load switch sequencer
`timescale 1ns/1ps
module tb_lsf_seq;
    import lsf_pkg::*;
    // --------------------------------
    // Short counts and stimulus
    // --------------------------------
    localparam int DEB = 16, ONI = 4, ONO = 4, STI = 10, STO = 24;
    localparam int BLK = 8, RET = 20, OCP = 6, FULL = DEB + ONI;
    localparam logic [1:0] PAIRS [3] = '{2'b00, 2'b01, 2'b11};
    localparam lsf_mode_t MODES [3] = '{LSF_AUTO, LSF_CONT, LSF_LATCH};
    logic clk_sys = 1'b0, reset_n = 1'b0, ce = 1'b1, uv_sel = 1'b0, ov_sel = 1'b0;
    logic out_above = 1'b0, drop = 1'b0, tsd = 1'b0, tfb = 1'b0, oc = 1'b0, soc = 1'b0;
    logic lsl = 1'b0, lso = 1'b0, mode_gnd = 1'b0, mode_open = 1'b1;
    logic [1:0] cmd = 2'b10;
    logic [3:0] lvl = 4'h0;
    logic [9:0] sn = 10'h000;
    logic hv_n, lv_en, inner, outer, hold, thr, blk, fault_n, fpo, foe, uvx, ovx, fseen;
    lsf_mode_t mode;
    int failures = 0, n_compared = 0;
    initial forever #10 clk_sys = ~clk_sys;
    // Settled copy of outputs, so checks never race the launching edge
    always @(negedge clk_sys) sn <= {ovx, uvx, fseen, thr, blk, hold, outer, inner, mode};
    lsf_super u_super (.clk_sys(clk_sys), .cmd(cmd), .high_voltage_enable_n(hv_n),
        .low_voltage_enable(lv_en), .fault_pin_out(fpo), .fault_pin_oe_n(foe),
        .fault_seen(fseen));
    lsf_seq #(.DEB_CYC(DEB), .ON_INNER_CYC(ONI), .ON_OUTER_CYC(ONO), .STI_CYC(STI),
        .STO_CYC(STO), .BLANK_CYC(BLK), .RETRY_CYC(RET), .OCP_OFF_CYC(OCP)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .high_voltage_enable_n(hv_n),
        .low_voltage_enable(lv_en), .uv_select_above(uv_sel), .uv_internal_below(lvl[0]),
        .uv_external_below(lvl[1]), .ov_select_above(ov_sel), .ov_internal_above(lvl[2]),
        .ov_external_above(lvl[3]), .out_above_uv_level(out_above), .drop_alarm(drop),
        .thermal_shutdown(tsd), .thermal_foldback(tfb), .overcurrent(oc),
        .severe_overcurrent(soc), .limit_set_low(lsl), .limit_set_open(lso),
        .limit_mode_grounded(mode_gnd), .limit_mode_open(mode_open),
        .inner_switch_on(inner), .outer_switch_on(outer), .current_limit_hold(hold),
        .thermal_regulate(thr), .current_block(blk), .limit_mode(mode),
        .uv_external_sel(uvx), .ov_external_sel(ovx), .fault_out_n(fault_n),
        .fault_pin_out(fpo), .fault_pin_oe_n(foe));
    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Waits a bounded time for a switch level; a hang shows as a late count
    task automatic t_sw(input int s, input logic v, input int lo, input int hi);
        int t;
        for (t = 0; t <= hi + 1 && sn[2 + s] !== v; t++) @(posedge clk_sys);
        chk(s ? "outer delay" : "inner delay", 2'h1, {1'b0, t >= lo && t <= hi});
    endtask
    task automatic run_up(input logic [1:0] c, input logic [1:0] m);
        cmd <= c;
        t_sw(0, 1'b1, FULL, FULL + 10);
        chk("outer early", 2'h0, {1'b0, sn[3]});
        t_sw(1, 1'b1, 1, ONO + 5);
        chk("startup hold", 2'h1, {1'b0, sn[4]});
        go(6);
        chk("limit mode", m, sn[1:0]);
    endtask
    // Trip one level comparator, then watch the staged recovery
    task automatic recover(input int k, input logic above, input int lo, input int hi);
        out_above <= above;
        lvl[k] <= 1'b1;
        t_sw(0, 1'b0, 1, 6);
        go(2);
        chk("fault pin", 2'h0, {1'b0, sn[7]});
        lvl[k] <= 1'b0;
        t_sw(0, 1'b1, lo, hi);
        t_sw(1, 1'b1, 1, ONO + 5);
        go(3);
        chk("fault pin", 2'h1, {1'b0, sn[7]});
    endtask
    task automatic close_out;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    initial begin
        go(12);
        reset_n <= 1'b1;
        chk("reset mode", LSF_CONT, sn[1:0]);
        chk("reset switches", 2'h0, sn[3:2]);
        chk("reset hold", 2'h1, {1'b0, sn[4]});
        go(40);
        chk("off pair", 2'h0, sn[3:2]);
        for (int i = 0; i < 3; i++) begin
            {mode_gnd, mode_open} <= 2'b10 >> i;
            run_up(PAIRS[i], MODES[i]);
            cmd <= 2'b10;
            t_sw(0, 1'b0, 1, 7);
            chk("outer off", 2'h0, {1'b0, sn[3]});
        end
        // Autoretry: a short overload is forgiven, a long one cycles the switch
        mode_gnd <= 1'b1;
        run_up(2'b00, LSF_AUTO);
        oc <= 1'b1;
        go(BLK - 3);
        oc <= 1'b0;
        go(BLK + 6);
        chk("blank reset", 2'h1, {1'b0, sn[2]});
        oc <= 1'b1;
        t_sw(0, 1'b0, BLK, BLK + 8);
        t_sw(0, 1'b1, RET, RET + ONI + 10);
        oc <= 1'b0;
        go(ONO + 10);
        out_above <= 1'b1;
        soc <= 1'b1;
        go(1);
        soc <= 1'b0;
        t_sw(0, 1'b0, 1, 6);
        chk("outer off", 2'h0, {1'b0, sn[3]});
        t_sw(0, 1'b1, OCP, OCP + ONI + 8);
        t_sw(1, 1'b1, 1, ONO + 5);
        go(6);
        recover(0, 1'b0, FULL, FULL + 10);
        recover(0, 1'b1, 1, ONI + 8);
        {uv_sel, ov_sel} <= 2'b11;
        lvl <= 4'b0101;
        go(10);
        chk("select ignores internal", 2'h3, {sn[8] & sn[9], sn[2]});
        // Frozen clock enable: a fresh undervoltage must not reach the sequencer
        {ce, lvl} <= 5'h02;
        go(10);
        chk("frozen inner", 2'h1, {1'b0, sn[2]});
        {ce, lvl} <= 5'h10;
        go(1);
        recover(1, 1'b0, FULL, FULL + 10);
        recover(3, 1'b1, 1, ONI + 8);
        // Output never charges after a fault restart: timeout latches it off
        lvl[1] <= 1'b1;
        t_sw(0, 1'b0, 1, 6);
        {drop, tfb} <= 2'b11;
        lvl[1] <= 1'b0;
        t_sw(0, 1'b1, 1, ONI + 8);
        go(ONO + 4);
        chk("thermal regulate", 2'h1, {1'b0, sn[6]});
        t_sw(0, 1'b0, STO - 6, STO + 8);
        {drop, tfb} <= 2'b00;
        go(30);
        chk("latched off", 2'h0, {1'b0, sn[2]});
        cmd <= 2'b10;
        go(8);
        run_up(2'b00, LSF_AUTO);
        {mode_gnd, mode_open, cmd} <= 4'b0010;
        go(8);
        run_up(2'b01, LSF_LATCH);
        oc <= 1'b1;
        t_sw(0, 1'b0, BLK, BLK + 8);
        oc <= 1'b0;
        go(40);
        chk("latch holds", 2'h0, {1'b0, sn[2]});
        lso <= 1'b1;
        go(5);
        chk("current block", 2'h1, {1'b0, sn[5]});
        {lsl, reset_n} <= 2'b10;
        go(3);
        {reset_n, cmd} <= 3'b100;
        go(FULL + 30);
        chk("small resistor", 2'h0, {sn[7], sn[2]});
        close_out;
    end
    // Watchdog well beyond the several hundred cycles the scenarios need
    initial begin
        go(20000);
        failures++;
        close_out;
    end
endmodule
